// ### common/mmr_space_pkg.sv
// Constants, register map and state encoding for the register space decoder.
// Assumes one system clock and a core that issues one register access at a time.
package mmr_space_pkg;

  // ---------------------------------------------------------------------------
  // Region and access encoding
  // ---------------------------------------------------------------------------
  localparam logic [15:0] REGION_TAG = 16'hFFFF;   // Upper address half of the two top pages
  localparam logic [1:0]  SIZE_BYTE  = 2'h0;
  localparam logic [1:0]  SIZE_HALF  = 2'h1;
  localparam logic [1:0]  SIZE_WORD  = 2'h2;
  localparam logic [7:0]  REMAP_RST  = 8'h01;      // Flash mirrored at zero after reset
  localparam logic [15:0] REMAP_OFF  = 16'h0220;

  // ---------------------------------------------------------------------------
  // Single-cycle local blocks
  // ---------------------------------------------------------------------------
  localparam logic [15:0] IRQ_BASE   = 16'h0000;
  localparam logic [15:0] IRQ_LIMIT  = 16'h013F;
  localparam logic [15:0] SYS_BASE   = 16'h0200;
  localparam logic [15:0] SYS_LIMIT  = 16'h02FF;

  // ---------------------------------------------------------------------------
  // System bus windows: GPIO, flash control 0, flash control 1
  // ---------------------------------------------------------------------------
  localparam int unsigned N_SB = 3;
  localparam logic [15:0] SB_LO [N_SB] = '{16'h0D00, 16'h0E00, 16'h0E80};
  localparam logic [15:0] SB_HI [N_SB] = '{16'h0D77, 16'h0E27, 16'h0EA7};

  // ---------------------------------------------------------------------------
  // Peripheral bus windows: timers, clocking, supply monitor, reference,
  // converters, current outputs, serial ports, logic array, PWM
  // ---------------------------------------------------------------------------
  localparam int unsigned N_PB = 13;
  localparam logic [15:0] PB_LO [N_PB] = '{16'h0300, 16'h0400, 16'h0440, 16'h0480, 16'h0500, 16'h0580,
                                           16'h0700, 16'h0800, 16'h0880, 16'h0900, 16'h0A00, 16'h0B00,
                                           16'h0F80};
  localparam logic [15:0] PB_HI [N_PB] = '{16'h0393, 16'h0418, 16'h0447, 16'h04A7, 16'h0523, 16'h05DF,
                                           16'h0745, 16'h082F, 16'h08CF, 16'h094F, 16'h0A13, 16'h0B53,
                                           16'h0FBB};

  // ---------------------------------------------------------------------------
  // Register descriptors of the single-cycle blocks
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic [15:0] off;
    logic        rd;
    logic        wr;
    logic [2:0]  bytes;
  } reg_desc_t;

  localparam int unsigned N_REG = 27;
  localparam reg_desc_t REG_TAB [N_REG] = '{
    '{16'h0000, 1'b1, 1'b0, 3'h4}, '{16'h0004, 1'b1, 1'b0, 3'h4}, '{16'h0008, 1'b1, 1'b1, 3'h4},
    '{16'h000C, 1'b0, 1'b1, 3'h4}, '{16'h0010, 1'b0, 1'b1, 3'h4}, '{16'h0014, 1'b1, 1'b1, 3'h4},
    '{16'h001C, 1'b1, 1'b1, 3'h4}, '{16'h0020, 1'b1, 1'b1, 3'h4}, '{16'h0024, 1'b1, 1'b1, 3'h4},
    '{16'h0028, 1'b1, 1'b1, 3'h4}, '{16'h002C, 1'b1, 1'b1, 3'h4}, '{16'h0030, 1'b1, 1'b1, 3'h1},
    '{16'h0034, 1'b1, 1'b1, 3'h4}, '{16'h0038, 1'b0, 1'b1, 3'h1}, '{16'h003C, 1'b1, 1'b1, 3'h1},
    '{16'h0100, 1'b1, 1'b0, 3'h4}, '{16'h0104, 1'b1, 1'b0, 3'h4}, '{16'h0108, 1'b1, 1'b1, 3'h4},
    '{16'h010C, 1'b0, 1'b1, 3'h4}, '{16'h011C, 1'b1, 1'b0, 3'h4}, '{16'h0138, 1'b1, 1'b1, 3'h1},
    '{16'h0220, 1'b1, 1'b1, 3'h1}, '{16'h0230, 1'b1, 1'b0, 3'h1}, '{16'h0234, 1'b0, 1'b1, 3'h1},
    '{16'h0248, 1'b0, 1'b1, 3'h1}, '{16'h024C, 1'b1, 1'b1, 3'h1}, '{16'h0250, 1'b0, 1'b1, 3'h1}
  };

  // ---------------------------------------------------------------------------
  // Access sequencer states
  // ---------------------------------------------------------------------------
  typedef enum logic [4:0] {
    ST_IDLE  = 5'b00001,
    ST_LOCAL = 5'b00010,
    ST_SETUP = 5'b00100,
    ST_ENABL = 5'b01000,
    ST_NULL  = 5'b10000
  } state_t;

endpackage

// ### logic/mmr_space_decoder.sv
// Register space decoder and bus timing front end for the top register pages.
// Assumes the core holds no second access open while core_busy is high and
// that every target answers read data combinationally while it is selected.
`timescale 1ns/10ps

module mmr_space_decoder (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  // Core register access
  input  wire logic        core_req,
  input  wire logic        core_wr,
  input  wire logic [31:0] core_addr,
  input  wire logic [1:0]  core_size,
  input  wire logic [31:0] core_wdata,
  output logic             core_busy,
  output logic             core_done,
  output logic             core_fault,
  output logic [31:0]      core_rdata,
  // Shared single-cycle target signals
  output logic [15:0]      loc_addr,
  output logic [31:0]      loc_wdata,
  output logic [3:0]       loc_be,
  output logic             loc_wr,
  // Interrupt controller block
  output logic             irq_sel,
  input  wire logic [31:0] irq_rdata,
  // System control block
  output logic             sysctl_sel,
  input  wire logic [31:0] sysctl_rdata,
  // System bus targets (flash control, GPIO)
  output logic             sbus_sel,
  input  wire logic [31:0] sbus_rdata,
  // Peripheral bus
  output logic             pb_sel,
  output logic             pb_enable,
  output logic             pb_write,
  output logic [31:0]      pb_addr,
  output logic [31:0]      pb_wdata,
  output logic [3:0]       pb_strb,
  input  wire logic [31:0] pb_rdata,
  // Memory remap control
  output logic [7:0]       remap_ctrl
);

  // ---------------------------------------------------------------------------
  // State record
  // ---------------------------------------------------------------------------
  typedef struct packed {
    mmr_space_pkg::state_t st;
    logic                  busy;
    logic                  done;
    logic                  fault;
    logic [31:0]           rdata;
    logic [31:0]           addr;
    logic [31:0]           wdata;
    logic [3:0]            be;
    logic                  wr;
    logic [31:0]           mask;
    logic                  irq_sel;
    logic                  sys_sel;
    logic                  sb_sel;
    logic                  pb_sel;
    logic                  pb_en;
    logic [7:0]            remap;
  } dec_state_t;

  localparam dec_state_t RESET_STATE = '{
    st:      mmr_space_pkg::ST_IDLE,
    busy:    1'b0,
    done:    1'b0,
    fault:   1'b0,
    rdata:   32'h0000_0000,
    addr:    32'h0000_0000,
    wdata:   32'h0000_0000,
    be:      4'h0,
    wr:      1'b0,
    mask:    32'h0000_0000,
    irq_sel: 1'b0,
    sys_sel: 1'b0,
    sb_sel:  1'b0,
    pb_sel:  1'b0,
    pb_en:   1'b0,
    remap:   mmr_space_pkg::REMAP_RST
  };

  dec_state_t s_q;
  dec_state_t s_d;

  // ---------------------------------------------------------------------------
  // Decode helpers
  // ---------------------------------------------------------------------------

  // Byte lanes of one access, little endian
  function automatic logic [3:0] lanes(input logic [1:0] size, input logic [1:0] low);
    logic [3:0] base;
    base = 4'h0;
    case (size)
      mmr_space_pkg::SIZE_BYTE: base = 4'h1;
      mmr_space_pkg::SIZE_HALF: base = 4'h3;
      default:                  base = 4'hF;
    endcase
    lanes = 4'((base << low) & 4'hF);
  endfunction

  // Read data mask for a register of the given byte width
  function automatic logic [31:0] width_mask(input logic [2:0] bytes);
    logic [31:0] m;
    m = 32'hFFFF_FFFF;
    case (bytes)
      3'h1:    m = 32'h0000_00FF;
      3'h2:    m = 32'h0000_FFFF;
      default: m = 32'hFFFF_FFFF;
    endcase
    width_mask = m;
  endfunction

  // Lookup in the descriptor table of the single-cycle blocks
  function automatic mmr_space_pkg::reg_desc_t find_reg(input logic [15:0] off, output logic hit);
    mmr_space_pkg::reg_desc_t d;
    d   = '0;
    hit = 1'b0;
    for (int i = 0; i < int'(mmr_space_pkg::N_REG); i++) begin
      if (mmr_space_pkg::REG_TAB[i].off == {off[15:2], 2'b00}) begin
        d   = mmr_space_pkg::REG_TAB[i];
        hit = 1'b1;
      end
    end
    find_reg = d;
  endfunction

  // Range test against a list of windows
  function automatic logic in_sbus(input logic [15:0] off);
    logic h;
    h = 1'b0;
    for (int i = 0; i < int'(mmr_space_pkg::N_SB); i++) begin
      if (off >= mmr_space_pkg::SB_LO[i] && off <= mmr_space_pkg::SB_HI[i]) begin
        h = 1'b1;
      end
    end
    in_sbus = h;
  endfunction

  function automatic logic in_pbus(input logic [15:0] off);
    logic h;
    h = 1'b0;
    for (int i = 0; i < int'(mmr_space_pkg::N_PB); i++) begin
      if (off >= mmr_space_pkg::PB_LO[i] && off <= mmr_space_pkg::PB_HI[i]) begin
        h = 1'b1;
      end
    end
    in_pbus = h;
  endfunction

  // ---------------------------------------------------------------------------
  // Address classification of the incoming request
  // ---------------------------------------------------------------------------
  logic [15:0]               req_off;
  logic                      in_region;
  logic                      in_irq;
  logic                      in_sys;
  logic                      req_sb;
  logic                      req_pb;
  logic                      reg_hit;
  mmr_space_pkg::reg_desc_t  reg_info;
  logic                      dir_ok;

  // Region test first, so nothing outside the top pages reaches a target
  always_comb begin
    req_off   = core_addr[15:0];
    in_region = (core_addr[31:16] == mmr_space_pkg::REGION_TAG);
    in_irq    = in_region && req_off >= mmr_space_pkg::IRQ_BASE
                && req_off <= mmr_space_pkg::IRQ_LIMIT;
    in_sys    = in_region && req_off >= mmr_space_pkg::SYS_BASE
                && req_off <= mmr_space_pkg::SYS_LIMIT;
    req_sb    = in_region && in_sbus(req_off);
    req_pb    = in_region && in_pbus(req_off);
    reg_info  = find_reg(req_off, reg_hit);
    dir_ok    = core_wr ? reg_info.wr : reg_info.rd;
  end

  // ---------------------------------------------------------------------------
  // Access sequencer
  // ---------------------------------------------------------------------------
  // Local and system bus targets see one strobe cycle, peripheral bus targets
  // a setup and an enable cycle; every access ends in one done pulse so that
  // a stray access to a hole never hangs the core.
  always_comb begin
    s_d       = s_q;
    s_d.done  = 1'b0;
    s_d.fault = 1'b0;
    case (s_q.st)
      mmr_space_pkg::ST_IDLE: begin
        if (core_req) begin
          s_d.busy  = 1'b1;
          s_d.addr  = core_addr;
          s_d.wdata = core_wdata;
          s_d.wr    = core_wr;
          s_d.be    = core_wr ? lanes(core_size, core_addr[1:0]) : 4'h0;
          s_d.mask  = 32'hFFFF_FFFF;
          s_d.rdata = 32'h0000_0000;
          if (in_irq || in_sys) begin
            s_d.mask = width_mask(reg_info.bytes);
            if (!reg_hit) begin
              s_d.st    = mmr_space_pkg::ST_NULL;
            end else if (!dir_ok) begin
              s_d.st = mmr_space_pkg::ST_NULL;
            end else if ({req_off[15:2], 2'b00} == mmr_space_pkg::REMAP_OFF) begin
              // Remap is held here because it steers the memory map itself
              s_d.st = mmr_space_pkg::ST_NULL;
              if (core_wr) begin
                if (lanes(core_size, core_addr[1:0]) != 4'h0) begin
                  s_d.remap = core_wdata[7:0];
                end
              end else begin
                s_d.rdata = {24'h00_0000, s_q.remap};
              end
            end else begin
              s_d.st      = mmr_space_pkg::ST_LOCAL;
              s_d.irq_sel = in_irq;
              s_d.sys_sel = in_sys;
            end
          end else if (req_sb) begin
            s_d.st     = mmr_space_pkg::ST_LOCAL;
            s_d.sb_sel = 1'b1;
          end else if (req_pb) begin
            s_d.st     = mmr_space_pkg::ST_SETUP;
            s_d.pb_sel = 1'b1;
          end else begin
            s_d.st = mmr_space_pkg::ST_NULL;
          end
        end
      end
      mmr_space_pkg::ST_LOCAL: begin
        // Capture at the end of the single strobe cycle
        if (!s_q.wr) begin
          if (s_q.irq_sel) begin
            s_d.rdata = irq_rdata & s_q.mask;
          end else if (s_q.sys_sel) begin
            s_d.rdata = sysctl_rdata & s_q.mask;
          end else begin
            s_d.rdata = sbus_rdata;
          end
        end
        s_d.irq_sel = 1'b0;
        s_d.sys_sel = 1'b0;
        s_d.sb_sel  = 1'b0;
        s_d.busy    = 1'b0;
        s_d.done    = 1'b1;
        s_d.st      = mmr_space_pkg::ST_IDLE;
      end
      mmr_space_pkg::ST_SETUP: begin
        s_d.pb_en = 1'b1;
        s_d.st    = mmr_space_pkg::ST_ENABL;
      end
      mmr_space_pkg::ST_ENABL: begin
        if (!s_q.wr) begin
          s_d.rdata = pb_rdata;
        end
        s_d.pb_sel = 1'b0;
        s_d.pb_en  = 1'b0;
        s_d.busy   = 1'b0;
        s_d.done   = 1'b1;
        s_d.st     = mmr_space_pkg::ST_IDLE;
      end
      mmr_space_pkg::ST_NULL: begin
        // Holes, wrong direction and remap: no target strobe, zero or local data
        s_d.busy  = 1'b0;
        s_d.done  = 1'b1;
        // Remap is the only null access that is not refused
        s_d.fault = !(s_q.addr[31:16] == mmr_space_pkg::REGION_TAG
                      && {s_q.addr[15:2], 2'b00} == mmr_space_pkg::REMAP_OFF);
        s_d.st    = mmr_space_pkg::ST_IDLE;
      end
      default: begin
        s_d = RESET_STATE;
      end
    endcase
  end

  // State register, asynchronous clear to constants only
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      s_q <= RESET_STATE;
    end else begin
      s_q <= s_d;
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs, all straight from the state record
  // ---------------------------------------------------------------------------
  assign core_busy  = s_q.busy;
  assign core_done  = s_q.done;
  assign core_fault = s_q.fault;
  assign core_rdata = s_q.rdata;
  assign loc_addr   = s_q.addr[15:0];
  assign loc_wdata  = s_q.wdata;
  assign loc_be     = s_q.be;
  assign loc_wr     = s_q.wr;
  assign irq_sel    = s_q.irq_sel;
  assign sysctl_sel = s_q.sys_sel;
  assign sbus_sel   = s_q.sb_sel;
  assign pb_sel     = s_q.pb_sel;
  assign pb_enable  = s_q.pb_en;
  assign pb_write   = s_q.wr;
  assign pb_addr    = s_q.addr;
  assign pb_wdata   = s_q.wdata;
  assign pb_strb    = s_q.be;
  assign remap_ctrl = s_q.remap;

endmodule // mmr_space_decoder

// ### sim/mmr_space_decoder_bench.sv
// Self-checking bench for the register space decoder.
// Assumes the target model answers {addr, ~addr} while a block is selected.
`timescale 1ns/10ps

module mmr_space_decoder_bench;
  // ---------------------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------------------
  logic        clk_sys, resetn, core_req, core_wr, core_busy, core_done, core_fault;
  logic [31:0] core_addr, core_wdata, core_rdata, irq_rdata, sysctl_rdata, sbus_rdata;
  logic [31:0] pb_addr, pb_wdata, pb_rdata, loc_wdata;
  logic [1:0]  core_size;
  logic        irq_sel, sysctl_sel, sbus_sel, pb_sel, pb_enable, pb_write, loc_wr;
  logic [15:0] loc_addr;
  logic [3:0]  loc_be, pb_strb, seen, be;
  logic [7:0]  remap_ctrl;
  int          n, err_count, num_checks;

  // wr, addr, size, wdata, rdata, fault, cycles, targets {pb,sb,sys,irq}, lanes
  typedef struct packed {
    logic wr; logic [31:0] addr; logic [1:0] size; logic [31:0] wdata;
    logic [31:0] rdata; logic fault; logic [1:0] lat; logic [3:0] tgt; logic [3:0] be;
  } row_t;
  localparam int N_ROWS = 20;
  localparam row_t ROWS [N_ROWS] = '{
    '{1'b0, 32'hFFFF0220, 2'h0, 32'h0, 32'h00000001, 1'b0, 2'h2, 4'h0, 4'h0},
    '{1'b1, 32'hFFFF0220, 2'h0, 32'h0, 32'h0, 1'b0, 2'h2, 4'h0, 4'h0},
    '{1'b0, 32'hFFFF0220, 2'h0, 32'h0, 32'h0, 1'b0, 2'h2, 4'h0, 4'h0},
    '{1'b0, 32'hFFFF0008, 2'h2, 32'h0, 32'h0008FFF7, 1'b0, 2'h2, 4'h1, 4'h0},
    '{1'b0, 32'hFFFF0030, 2'h2, 32'h0, 32'h000000CF, 1'b0, 2'h2, 4'h1, 4'h0},
    '{1'b1, 32'hFFFF000C, 2'h2, 32'h12345678, 32'h0, 1'b0, 2'h2, 4'h1, 4'hF},
    '{1'b0, 32'hFFFF000C, 2'h2, 32'h0, 32'h0, 1'b1, 2'h2, 4'h0, 4'h0},
    '{1'b1, 32'hFFFF0000, 2'h2, 32'h1, 32'h0, 1'b1, 2'h2, 4'h0, 4'h0},
    '{1'b0, 32'hFFFF0018, 2'h2, 32'h0, 32'h0, 1'b1, 2'h2, 4'h0, 4'h0},
    '{1'b0, 32'hFFFF0230, 2'h0, 32'h0, 32'h000000CF, 1'b0, 2'h2, 4'h2, 4'h0},
    '{1'b0, 32'hFFFF0D04, 2'h2, 32'h0, 32'h0D04F2FB, 1'b0, 2'h2, 4'h4, 4'h0},
    '{1'b1, 32'hFFFF0E80, 2'h1, 32'h0000BEEF, 32'h0, 1'b0, 2'h2, 4'h4, 4'h3},
    '{1'b0, 32'hFFFF0300, 2'h2, 32'h0, 32'h0300FCFF, 1'b0, 2'h3, 4'h8, 4'h0},
    '{1'b0, 32'hFFFF0500, 2'h2, 32'h0, 32'h0500FAFF, 1'b0, 2'h3, 4'h8, 4'h0},
    '{1'b1, 32'hFFFF0502, 2'h1, 32'hBEEF0000, 32'h0, 1'b0, 2'h3, 4'h8, 4'hC},
    '{1'b1, 32'hFFFF0F80, 2'h3, 32'hCAFE0001, 32'h0, 1'b0, 2'h3, 4'h8, 4'hF},
    '{1'b1, 32'hFFFF0234, 2'h0, 32'h00000001, 32'h0, 1'b0, 2'h2, 4'h2, 4'h1},
    '{1'b0, 32'hFFFF0600, 2'h2, 32'h0, 32'h0, 1'b1, 2'h2, 4'h0, 4'h0},
    '{1'b0, 32'h00080000, 2'h2, 32'h0, 32'h0, 1'b1, 2'h2, 4'h0, 4'h0},
    '{1'b0, 32'hFFFF1000, 2'h2, 32'h0, 32'h0, 1'b1, 2'h2, 4'h0, 4'h0}
  };

  // ---------------------------------------------------------------------------
  // Design, targets and clock
  // ---------------------------------------------------------------------------
  mmr_space_decoder dut (.clk_sys, .resetn, .core_req, .core_wr, .core_addr, .core_size, .core_wdata,
    .core_busy, .core_done, .core_fault, .core_rdata, .loc_addr, .loc_wdata, .loc_be, .loc_wr, .irq_sel,
    .irq_rdata, .sysctl_sel, .sysctl_rdata, .sbus_sel, .sbus_rdata, .pb_sel, .pb_enable, .pb_write,
    .pb_addr, .pb_wdata, .pb_strb, .pb_rdata, .remap_ctrl);
  mmr_target_model u_targets (.clk_sys, .resetn, .loc_addr, .irq_sel, .sysctl_sel, .sbus_sel, .irq_rdata,
    .sysctl_rdata, .sbus_rdata, .pb_enable, .pb_addr, .pb_rdata);

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // ---------------------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic drv(input row_t r);
    core_wr    <= r.wr;
    core_addr  <= r.addr;
    core_size  <= r.size;
    core_wdata <= r.wdata;
  endtask

  // One access; returns in the done cycle, with cycles, strobes and lanes seen
  task automatic go(input row_t r);
    @(posedge clk_sys);
    drv(r);
    core_req <= 1'b1;
    @(posedge clk_sys);
    core_req <= 1'b0;
    n = 0;
    seen = 4'h0;
    be = 4'h0;
    do begin
      #1;
      n++;
      seen |= {pb_sel, sbus_sel, sysctl_sel, irq_sel};
      if (irq_sel || sysctl_sel || sbus_sel) be |= loc_be;
      if (pb_sel) be |= pb_strb;
      if (core_done !== 1'b1 && n < 8) @(posedge clk_sys);
    end while (core_done !== 1'b1 && n < 8);
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Watchdog well beyond the roughly 90 cycles the run needs
  initial begin
    repeat (5000) @(posedge clk_sys);
    err_count++;
    report_and_stop();
  end

  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial begin
    err_count = 0;
    num_checks = 0;
    resetn = 1'b0;
    core_req = 1'b0;
    core_wr = 1'b0;
    core_addr = 32'h0;
    core_size = 2'h0;
    core_wdata = 32'h0;
    repeat (11) @(posedge clk_sys);
    #1;
    check("remap at reset", {24'h0, remap_ctrl}, 32'h00000001);
    check("busy at reset", {30'h0, core_busy, pb_sel}, 32'h0);
    @(posedge clk_sys);
    resetn <= 1'b1;
    for (int i = 0; i < N_ROWS; i++) begin
      go(ROWS[i]);
      check("rdata", core_rdata, ROWS[i].rdata);
      check("fault", {31'h0, core_fault}, {31'h0, ROWS[i].fault});
      check("cycles", 32'(n), {30'h0, ROWS[i].lat});
      check("targets", {26'h0, loc_wr, pb_write, seen}, {26'h0, ROWS[i].wr, ROWS[i].wr, ROWS[i].tgt});
      check("wdata", ROWS[i].tgt[3] ? pb_wdata : loc_wdata, ROWS[i].wdata);
      check("lanes", {28'h0, be}, {28'h0, ROWS[i].be});
    end
    // Request held through busy is ignored, then taken in the done cycle
    @(posedge clk_sys);
    drv(ROWS[3]);
    core_req <= 1'b1;
    @(posedge clk_sys);
    drv(ROWS[10]);
    @(posedge clk_sys);
    #1;
    check("first done", {31'h0, core_done}, 32'h1);
    check("first rdata", core_rdata, 32'h0008FFF7);
    @(posedge clk_sys);
    core_req <= 1'b0;
    #1;
    check("second taken", {16'h0, loc_addr}, 32'h00000D04);
    @(posedge clk_sys);
    #1;
    check("second done", {31'h0, core_done}, 32'h1);
    check("second rdata", core_rdata, 32'h0D04F2FB);
    // Reset in the middle of a peripheral bus access
    @(posedge clk_sys);
    drv(ROWS[13]);
    core_req <= 1'b1;
    @(posedge clk_sys);
    core_req <= 1'b0;
    @(posedge clk_sys);
    resetn <= 1'b0;
    #1;
    check("pb after reset", {30'h0, pb_sel, pb_enable}, 32'h0);
    check("remap after reset", {24'h0, remap_ctrl}, 32'h00000001);
    @(posedge clk_sys);
    resetn <= 1'b1;
    go(ROWS[12]);
    check("rdata after reset", core_rdata, ROWS[12].rdata);
    report_and_stop();
  end
endmodule // mmr_space_decoder_bench

// ### sim/mmr_space_decoder_properties.sv
// Checker for the register space decoder: strobe timing, routing and faults.
// Assumes it is bound to the decoder and sees its ports only.
`timescale 1ns/10ps

module mmr_space_decoder_checker (
  // Clock and reset
  input wire logic        clk_sys,
  input wire logic        resetn,
  // Core side
  input wire logic        core_req,
  input wire logic        core_wr,
  input wire logic [31:0] core_addr,
  input wire logic [31:0] core_wdata,
  input wire logic        core_busy,
  input wire logic        core_done,
  input wire logic        core_fault,
  input wire logic [31:0] core_rdata,
  // Target side
  input wire logic [15:0] loc_addr,
  input wire logic [3:0]  loc_be,
  input wire logic        loc_wr,
  input wire logic        irq_sel,
  input wire logic        sysctl_sel,
  input wire logic        sbus_sel,
  input wire logic        pb_sel,
  input wire logic        pb_enable,
  input wire logic [31:0] pb_addr,
  input wire logic [7:0]  remap_ctrl
);
  // ---------------------------------------------------------------------------
  // Accepted request capture
  // ---------------------------------------------------------------------------
  logic        take;
  logic [31:0] addr_q;
  logic [31:0] wdata_q;

  // Taken only while idle, the done cycle included
  assign take = core_req && !core_busy;

  // Kept so each strobe can be tied back to the request that caused it
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      addr_q  <= 32'h0;
      wdata_q <= 32'h0;
    end else if (take) begin
      addr_q  <= core_addr;
      wdata_q <= core_wdata;
    end
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);

  // ---------------------------------------------------------------------------
  // Peripheral bus steps
  // ---------------------------------------------------------------------------
  sequence s_pb_setup;
    pb_sel && !pb_enable;
  endsequence
  sequence s_pb_access;
    pb_sel && pb_enable;
  endsequence
  sequence s_pb_close;
    !pb_sel && core_done && !core_busy;
  endsequence

  // ---------------------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------------------
  property p_irq_one;
    irq_sel |=> !irq_sel && core_done && !core_fault;
  endproperty
  property p_irq_base;
    irq_sel |-> addr_q[31:16] == 16'hFFFF && addr_q[15:0] <= 16'h013F && loc_addr == addr_q[15:0];
  endproperty
  property p_sys_one;
    sysctl_sel |-> loc_addr[15:8] == 8'h02 ##1 (!sysctl_sel && core_done);
  endproperty
  property p_sb_one;
    sbus_sel |-> (loc_addr[15:8] == 8'h0D || loc_addr[15:8] == 8'h0E) ##1 (!sbus_sel && core_done);
  endproperty
  property p_pb_two;
    $rose(pb_sel) |-> s_pb_setup ##1 s_pb_access ##1 s_pb_close;
  endproperty
  property p_pb_addr;
    $rose(pb_sel) |-> pb_addr == addr_q && pb_addr[15:8] != 8'h0D && pb_addr[15:8] != 8'h0E;
  endproperty
  property p_take;
    take |=> core_busy ##[1:2] (core_done && !core_busy);
  endproperty
  property p_outside;
    take && core_addr[31:16] != 16'hFFFF |=> !(irq_sel || sysctl_sel || sbus_sel || pb_sel)
      ##1 (core_done && core_fault && core_rdata == 32'h0);
  endproperty
  property p_fault_zero;
    core_done && core_fault |-> core_rdata == 32'h0 && !core_busy;
  endproperty
  property p_rd_be;
    (irq_sel || sysctl_sel || sbus_sel) && !loc_wr |-> loc_be == 4'h0;
  endproperty
  property p_remap;
    take && core_wr && core_addr == 32'hFFFF0220 |=> remap_ctrl == wdata_q[7:0];
  endproperty

  a_irq_one:    assert property (p_irq_one)    else $error("interrupt strobe not single cycle");
  a_irq_base:   assert property (p_irq_base)   else $error("interrupt strobe outside its block");
  a_sys_one:    assert property (p_sys_one)    else $error("system control strobe wrong");
  a_sb_one:     assert property (p_sb_one)     else $error("system bus strobe wrong");
  a_pb_two:     assert property (p_pb_two)     else $error("peripheral bus not two cycles");
  a_pb_addr:    assert property (p_pb_addr)    else $error("peripheral bus address wrong");
  a_take:       assert property (p_take)       else $error("access latency wrong");
  a_outside:    assert property (p_outside)    else $error("outside access not faulted");
  a_fault_zero: assert property (p_fault_zero) else $error("faulted access returned data");
  a_rd_be:      assert property (p_rd_be)      else $error("byte enables on a read");
  a_remap:      assert property (p_remap)      else $error("remap not loaded");
endmodule // mmr_space_decoder_checker

bind mmr_space_decoder mmr_space_decoder_checker u_checker (.clk_sys, .resetn, .core_req, .core_wr, .core_addr,
  .core_wdata, .core_busy, .core_done, .core_fault, .core_rdata, .loc_addr, .loc_be, .loc_wr, .irq_sel,
  .sysctl_sel, .sbus_sel, .pb_sel, .pb_enable, .pb_addr, .remap_ctrl);

// ### sim/mmr_target_model.sv
// Target model for the decoder's far side: local register blocks and peripheral bus.
// Assumes read data is wanted combinationally while a block is selected.
`timescale 1ns/10ps

module mmr_target_model (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  // Local targets
  input  wire logic [15:0] loc_addr,
  input  wire logic        irq_sel,
  input  wire logic        sysctl_sel,
  input  wire logic        sbus_sel,
  output logic [31:0]      irq_rdata,
  output logic [31:0]      sysctl_rdata,
  output logic [31:0]      sbus_rdata,
  // Peripheral bus
  input  wire logic        pb_enable,
  input  wire logic [31:0] pb_addr,
  output logic [31:0]      pb_rdata
);
  // ---------------------------------------------------------------------------
  // Idle pattern
  // ---------------------------------------------------------------------------
  logic [31:0] noise_q;

  // Moves every cycle so stale data never passes for an answer
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      noise_q <= 32'h5A5A3C3C;
    end else begin
      noise_q <= {noise_q[30:0], noise_q[31]} ^ 32'h00000101;
    end
  end

  // Address-derived answers while selected, peripheral bus only while enabled, no wait states
  assign irq_rdata    = irq_sel ? {loc_addr, ~loc_addr} : noise_q;
  assign sysctl_rdata = sysctl_sel ? {loc_addr, ~loc_addr} : ~noise_q;
  assign sbus_rdata   = sbus_sel ? {loc_addr, ~loc_addr} : noise_q;
  assign pb_rdata     = pb_enable ? {pb_addr[15:0], ~pb_addr[15:0]} : ~noise_q;
endmodule // mmr_target_model
